// ==== design/rtcv_calendar_regs.sv ====
// calendar date value registers behind an AHB-Lite slave: configuration
// register with window pointer, and a value window onto the time/date regs
// assumes a single AHB-Lite master, word transfers, hclk at 100 MHz
//
// Implementation choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`include "rtcv_params.svh"

module rtcv_calendar_regs #(
	parameter int unsigned HALF_SEC_CYCLES = `RTCV_HALF_SEC_CYCLES
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	output logic             clock_module_enable
);
	import rtcv_pkg::*;

	rtcv_state_type st;
	rtcv_state_type next_st;

	logic half_tick;
	logic rollover_sync_flag;

	// address phase qualifiers, and the half-flag clear from a write's data phase
	logic            take;
	rtcv_target_type addr_tgt;
	logic [1:0]      sel_ptr;
	logic            clear_half;

	rtcv_half_timer #(
		.PERIOD (HALF_SEC_CYCLES)
	) u_timer (
		.hclk    (hclk),
		.hresetn (hresetn),
		.enable  (st.en),
		.tick    (half_tick),
		.sync    (rollover_sync_flag)
	);

	function automatic logic [15:0] year_word(input rtcv_state_type s);
		logic [15:0] w;
		w = 16'h0000;
		w[`RTCV_YR_TEN_LSB +: 4] = s.yr_ten;
		w[`RTCV_YR_ONE_LSB +: 4] = s.yr_one;
		return w;
	endfunction

	function automatic logic [15:0] mthday_word(input rtcv_state_type s);
		logic [15:0] w;
		w = 16'h0000;
		w[`RTCV_MTH_TEN_BIT] = s.mth_ten;
		w[`RTCV_MTH_ONE_LSB +: 4] = s.mth_one;
		w[`RTCV_DAY_TEN_LSB +: 2] = s.day_ten;
		w[`RTCV_DAY_ONE_LSB +: 4] = s.day_one;
		return w;
	endfunction

	function automatic logic [15:0] window_word(
		input rtcv_state_type s,
		input logic [1:0]     p
	);
		logic [15:0] w;
		w = 16'h0000;
		unique case (p)
			`RTCV_PTR_YEAR:   w = year_word(s);
			`RTCV_PTR_MTHDAY: w = mthday_word(s);
			`RTCV_PTR_WKHR:   w = s.wkhr;
			`RTCV_PTR_MINUTES_SECONDS_VALUE: w = s.minutes_seconds_value;
		endcase
		return w;
	endfunction

	function automatic logic [15:0] cfg_word(
		input rtcv_state_type s,
		input logic           sync
	);
		logic [15:0] w;
		w = 16'h0000;
		w[`RTCV_CFG_EN_BIT] = s.en;
		w[`RTCV_CFG_UNLOCK_BIT] = s.unlock;
		w[`RTCV_CFG_SYNC_BIT] = sync;
		w[`RTCV_CFG_HALF_BIT] = s.half;
		w[`RTCV_CFG_PTR_LSB +: 2] = s.ptr;
		return w;
	endfunction

	// decode the address phase; upper address bits alias, hsel picks region
	always_comb begin
		take = hsel && hready && htrans[1];
		addr_tgt = TGT_NONE;
		if (haddr[`RTCV_DECODE_MSB:0] == `RTCV_OFS_CFG) begin
			addr_tgt = TGT_CFG;
		end else if (haddr[`RTCV_DECODE_MSB:0] == `RTCV_OFS_WINDOW) begin
			addr_tgt = TGT_WINDOW;
		end
	end

	always_comb begin
		next_st = st;
		next_st.resp = 1'b0;
		next_st.readyout = 1'b1;
		clear_half = 1'b0;
		sel_ptr = `RTCV_PTR_MINUTES_SECONDS_VALUE;

		// data phase of a write: apply the stored data first so that a read
		// in the same cycle already sees it
		if (st.ph_wr) begin
			unique case (st.ph_tgt)
				TGT_CFG: begin
					if (st.unlock) begin
						next_st.en = hwdata[`RTCV_CFG_EN_BIT];
					end
					next_st.unlock = hwdata[`RTCV_CFG_UNLOCK_BIT];
					next_st.ptr = hwdata[`RTCV_CFG_PTR_LSB +: 2];
				end
				TGT_WINDOW: begin
					if (st.unlock) begin
						unique case (st.ph_ptr)
							`RTCV_PTR_YEAR: begin
								next_st.yr_ten =
									hwdata[`RTCV_YR_TEN_LSB +: 4];
								next_st.yr_one =
									hwdata[`RTCV_YR_ONE_LSB +: 4];
							end
							`RTCV_PTR_MTHDAY: begin
								next_st.mth_ten =
									hwdata[`RTCV_MTH_TEN_BIT];
								next_st.mth_one =
									hwdata[`RTCV_MTH_ONE_LSB +: 4];
								next_st.day_ten =
									hwdata[`RTCV_DAY_TEN_LSB +: 2];
								next_st.day_one =
									hwdata[`RTCV_DAY_ONE_LSB +: 4];
							end
							`RTCV_PTR_WKHR: begin
								next_st.wkhr = hwdata[15:0];
							end
							`RTCV_PTR_MINUTES_SECONDS_VALUE: begin
								next_st.minutes_seconds_value = hwdata[15:0];
							end
						endcase
					end
					// word writes always cover the low half; the flag is
					// cleared even when the value itself is locked
					if (st.ph_ptr == `RTCV_PTR_MINUTES_SECONDS_VALUE) begin
						clear_half = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end

		// half-second flag: a tick in the clearing cycle still counts
		if (half_tick) begin
			next_st.half = clear_half ? 1'b1 : ~st.half;
		end else if (clear_half) begin
			next_st.half = 1'b0;
		end

		// address phase
		next_st.ph_wr = take && hwrite && (addr_tgt != TGT_NONE);
		next_st.ph_tgt = take ? addr_tgt : TGT_NONE;
		next_st.ph_ptr = next_st.ptr;
		next_st.rdata = 32'h0000_0000;
		sel_ptr = next_st.ptr;

		if (take && !hwrite) begin
			unique case (addr_tgt)
				TGT_CFG: begin
					next_st.rdata = {16'h0000,
						cfg_word(next_st, rollover_sync_flag)};
				end
				TGT_WINDOW: begin
					next_st.rdata = {16'h0000,
						window_word(next_st, sel_ptr)};
				end
				TGT_NONE: begin
					next_st.rdata = 32'h0000_0000;
				end
				default: begin
					next_st.rdata = 32'h0000_0000;
				end
			endcase
		end

		// each window access steps the pointer down, stopping at zero, so
		// software can walk year, month/day, weekday/hours, min/sec in turn
		if (take && (addr_tgt == TGT_WINDOW)) begin
			if (next_st.ptr != `RTCV_PTR_MINUTES_SECONDS_VALUE) begin
				next_st.ptr = next_st.ptr - 2'b01;
			end
		end
	end

	// value registers reset to zero rather than stay unknown, which keeps
	// simulation free of x while software is expected to load them anyway
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st <= '0;
			st.readyout <= 1'b1;
			st.ptr <= `RTCV_RST_PTR;
			st.minutes_seconds_value <= `RTCV_RST_VALUE;
			st.wkhr <= `RTCV_RST_VALUE;
		end else begin
			st <= next_st;
		end
	end

	// hsize is not decoded: only whole-word transfers are supported
	logic unused_size;
	assign unused_size = ^hsize;

	assign hreadyout = st.readyout;
	assign hresp = st.resp;
	assign hrdata = st.rdata;
	assign clock_module_enable = st.en;

endmodule // rtcv_calendar_regs

// ==== pkg/rtcv_params.svh ====
// register offsets, field positions, reset values and timing for the
// calendar value block; assumes a 100 MHz hclk and word-wide AHB access
`ifndef RTCV_PARAMS_SVH
`define RTCV_PARAMS_SVH

// byte offsets inside the slave's address region
`define RTCV_OFS_CFG          12'h000
`define RTCV_OFS_WINDOW       12'h004
`define RTCV_DECODE_MSB       11

// configuration register fields
`define RTCV_CFG_EN_BIT       15
`define RTCV_CFG_UNLOCK_BIT   13
`define RTCV_CFG_SYNC_BIT     12
`define RTCV_CFG_HALF_BIT     11
`define RTCV_CFG_PTR_LSB      8

// window pointer codes
`define RTCV_PTR_MINUTES_SECONDS_VALUE       2'b00
`define RTCV_PTR_WKHR         2'b01
`define RTCV_PTR_MTHDAY       2'b10
`define RTCV_PTR_YEAR         2'b11

// year register fields
`define RTCV_YR_TEN_LSB       4
`define RTCV_YR_ONE_LSB       0

// month and day register fields
`define RTCV_MTH_TEN_BIT      12
`define RTCV_MTH_ONE_LSB      8
`define RTCV_DAY_TEN_LSB      4
`define RTCV_DAY_ONE_LSB      0

// reset values
`define RTCV_RST_PTR          2'b00
`define RTCV_RST_VALUE        16'h0000

// timing
`define RTCV_CLK_MHZ          100
`define RTCV_HALF_SEC_MS      500
`define RTCV_HALF_SEC_CYCLES  (`RTCV_HALF_SEC_MS * 1000 * `RTCV_CLK_MHZ)
`define RTCV_SYNC_CYCLES      32

`endif

// ==== pkg/rtcv_pkg.sv ====
// types shared by the calendar value block and its half-second timer
// assumes rtcv_params.svh supplies every number
package rtcv_pkg;

	typedef enum logic [1:0] {
		TGT_NONE   = 2'b00,
		TGT_CFG    = 2'b01,
		TGT_WINDOW = 2'b10
	} rtcv_target_type;

	typedef struct packed {
		logic            ph_wr;
		rtcv_target_type ph_tgt;
		logic [1:0]      ph_ptr;
		logic [31:0]     rdata;
		logic            resp;
		logic            readyout;
		logic            en;
		logic            unlock;
		logic [1:0]      ptr;
		logic            half;
		logic [3:0]      yr_ten;
		logic [3:0]      yr_one;
		logic            mth_ten;
		logic [3:0]      mth_one;
		logic [1:0]      day_ten;
		logic [3:0]      day_one;
		logic [15:0]     minutes_seconds_value;
		logic [15:0]     wkhr;
	} rtcv_state_type;

	typedef struct packed {
		logic [25:0] count;
		logic        tick;
		logic        sync;
	} rtcv_timer_type;

endpackage

// ==== design/rtcv_half_timer.sv ====
// half-second time base: counts hclk cycles while enabled, pulses tick
// once per half second and flags the cycles just before each rollover
`timescale 1ns/1ns
`include "rtcv_params.svh"

module rtcv_half_timer #(
	parameter int unsigned PERIOD = `RTCV_HALF_SEC_CYCLES
) (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic enable,
	output logic      tick,
	output logic      sync
);
	import rtcv_pkg::*;

	localparam logic [25:0] LAST = 26'(PERIOD - 1);
	localparam logic [25:0] SYNC_FROM = 26'(PERIOD - `RTCV_SYNC_CYCLES);

	rtcv_timer_type st;
	rtcv_timer_type next_st;

	always_comb begin
		next_st = st;
		next_st.tick = 1'b0;
		if (!enable) begin
			// a stopped clock restarts a full half period later
			next_st.count = 26'h000_0000;
		end else if (st.count == LAST) begin
			next_st.count = 26'h000_0000;
			next_st.tick = 1'b1;
		end else begin
			next_st.count = st.count + 26'h000_0001;
		end
		next_st.sync = enable && (next_st.count >= SYNC_FROM);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign tick = st.tick;
	assign sync = st.sync;

endmodule // rtcv_half_timer

// ==== verif/rtcv_calendar_chk.sv ====
// checker bound to the calendar value block's AHB-Lite ports
// assumes cfg at offset 0x000 and the value window at 0x004
`timescale 1ns/1ns

module rtcv_calendar_chk (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	input wire logic        clock_module_enable
);
	logic        tk, win, u, dw, dr, dc, dv, eu, mw, ry, rm;
	logic [1:0]  p, mp, wp;
	logic [7:0]  yr;
	logic [15:0] md;
	assign tk = hsel & hready & htrans[1];
	assign win = haddr[11:0] == 12'h004;
	// a cfg write in its data phase lands before the window step
	assign mp = dc & dw ? hwdata[9:8] : p;
	assign eu = dc & dw & u;
	assign mw = dv & dw & wp == 2'h0;
	assign ry = dr & dv & wp == 2'h3;
	assign rm = dr & dv & wp == 2'h2;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{p, wp, u, dw, dr, dc, dv, yr, md} <= '0;
		end else begin
			p <= (tk & win & mp != 2'h0) ? mp - 2'h1 : mp;
			wp <= mp;
			dw <= tk & hwrite;
			dr <= tk & !hwrite;
			dc <= tk & haddr[11:0] == 12'h000;
			dv <= tk & win;
			if (dc & dw) u <= hwdata[13];
			if (dv & dw & u & wp == 2'h3) yr <= hwdata[7:0];
			if (dv & dw & u & wp == 2'h2) md <= hwdata[15:0] & 16'h1f3f;
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	chk_en_unlock: assert property (
		$changed(clock_module_enable) |-> $past(eu) || $past(eu, 2))
		else $error("enable moved without unlock");
	chk_en_locked: assert property (
		dc & dw & !u |=> $stable(clock_module_enable))
		else $error("locked write moved enable");
	// the cfg read may overlap the write's data phase or follow it in the next cycle
	chk_half_clear: assert property (
		dr & dc & ($past(mw) | $past(mw, 2)) & !clock_module_enable
		|-> !hrdata[11])
		else $error("half flag not cleared");
	chk_year_pad: assert property (ry |-> hrdata[15:8] == 8'h00)
		else $error("year high byte set");
	chk_year_value: assert property (
		ry |-> hrdata[7:0] == yr) else $error("year digits wrong");
	chk_md_pad: assert property (
		rm |-> (hrdata[15:0] & 16'he0c0) == 16'h0000)
		else $error("month day pad set");
	chk_month_value: assert property (
		rm |-> hrdata[12:8] == md[12:8]) else $error("month wrong");
	chk_day_value: assert property (
		rm |-> hrdata[5:0] == md[5:0]) else $error("day wrong");
endmodule // rtcv_calendar_chk

bind rtcv_calendar_regs rtcv_calendar_chk u_chk (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
	.hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.hrdata(hrdata), .clock_module_enable(clock_module_enable));

// ==== verif/calendar_date_value_registers_bench.sv ====
// self-checking bench for the calendar value block as an AHB-Lite slave
// assumes it is the only master; hsel and hsize stay constant
`timescale 1ns/1ns

module calendar_date_value_registers_bench;
	localparam logic [11:0] CFG = 12'h000;
	localparam logic [11:0] WIN = 12'h004;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic [31:0] haddr = '0;
	logic [1:0]  htrans = '0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = '0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        en;
	int          n_fail = 0;
	int          n_compared = 0;

	// a short half second keeps the flag test to a few hundred cycles
	rtcv_calendar_regs #(.HALF_SEC_CYCLES(100)) DUT (
		.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .clock_module_enable(en));

	initial begin
		forever #5 hclk = ~hclk;
	end

	task automatic chk(input logic [15:0] g, input logic [15:0] e,
		input string m);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask

	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [15:0] d, output logic [31:0] q);
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {20'h0_0000, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {16'h0000, d};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
		chk({15'h0000, hresp}, 16'h0000, "response not okay");
	endtask

	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask

	task automatic rc(input logic [11:0] a, input logic [15:0] e,
		input string m);
		logic [31:0] q;
		xfer(1'b0, a, 16'h0000, q);
		chk(q[15:0], e, m);
		chk(q[31:16], 16'h0000, "upper half set");
	endtask

	// two edges let the enable output settle through up to two flops
	task automatic en_is(input logic e);
		repeat (2) @(posedge hclk);
		chk({15'h0000, en}, {15'h0000, e}, "enable level");
	endtask

	task automatic t_lock;
		wr(CFG, 16'h8300);
		wr(WIN, 16'h0099);
		wr(WIN, 16'h1231);
		wr(12'h010, 16'h2000);
		en_is(1'b0);
		wr(CFG, 16'h0300);
		rc(WIN, 16'h0000, "locked year");
		rc(WIN, 16'h0000, "locked month day");
		rc(12'h010, 16'h0000, "unmapped");
		$display("t_lock done");
	endtask

	task automatic t_fields;
		wr(CFG, 16'h2300);
		wr(WIN, 16'hff59);
		wr(WIN, 16'hffff);
		wr(CFG, 16'h2300);
		rc(WIN, 16'h0059, "year digits");
		rc(WIN, 16'h1f3f, "month day pads");
		wr(CFG, 16'h2200);
		wr(WIN, 16'h1231);
		wr(CFG, 16'h2200);
		rc(WIN, 16'h1231, "month day digits");
		wr(WIN, 16'h0a0b);
		wr(WIN, 16'h1234);
		wr(CFG, 16'h2100);
		rc(WIN, 16'h0a0b, "weekday hours");
		rc(WIN, 16'h1234, "minutes seconds");
		// a wrapping pointer would show the year here instead
		rc(WIN, 16'h1234, "pointer past zero");
		$display("t_fields done");
	endtask

	task automatic t_half;
		logic [31:0] q = '0;
		wr(CFG, 16'ha000);
		en_is(1'b1);
		for (int i = 0; i < 80 && q[11] !== 1'b1; i++)
			xfer(1'b0, CFG, 16'h0000, q);
		wr(CFG, 16'h2000);
		xfer(1'b0, CFG, 16'h0000, q);
		chk({15'h0000, q[11]}, 16'h0001, "half flag lost");
		wr(WIN, 16'h0000);
		xfer(1'b0, CFG, 16'h0000, q);
		chk({15'h0000, q[11]}, 16'h0000, "half not cleared");
		wr(CFG, 16'h2800);
		xfer(1'b0, CFG, 16'h0000, q);
		chk({15'h0000, q[11]}, 16'h0000, "half writable");
		$display("t_half done");
	endtask

	// software side: trust a value read in the sync window only in pairs
	task automatic t_sync;
		logic [31:0] q = '0;
		logic [31:0] r;
		wr(CFG, 16'ha300);
		for (int i = 0; i < 80 && q[12] !== 1'b1; i++)
			xfer(1'b0, CFG, 16'h0000, q);
		chk({15'h0000, q[12]}, 16'h0001, "sync never set");
		xfer(1'b0, WIN, 16'h0000, q);
		wr(CFG, 16'ha300);
		xfer(1'b0, WIN, 16'h0000, r);
		chk(q[15:0], r[15:0], "reads disagree");
		chk(r[15:0], 16'h0059, "year during sync");
		wr(CFG, 16'h2000);
		$display("t_sync done");
	endtask

	task automatic print_verdict;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge hclk);
		n_fail++;
		$display("[FAIL] %0t timeout", $time);
		print_verdict();
	end

	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_lock();
		t_fields();
		t_half();
		t_sync();
		print_verdict();
	end
endmodule // calendar_date_value_registers_bench
